// ---- rtl/pcl_pkg.sv ----
// constants shared by the loop control block and its lock timer
// ****************************************
// ****************************************
package pcl_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [15:0] PCL_IDX_FEEDBACK = 16'hF000;
  localparam logic [15:0] PCL_IDX_PRESCALE = 16'hF001;
  localparam logic [15:0] PCL_IDX_SOURCE = 16'hF002;
  localparam logic [15:0] PCL_IDX_POWER = 16'hF003;
  localparam logic [15:0] PCL_IDX_LOCK = 16'hF004;
  localparam logic [15:0] PCL_IDX_CLOCK_OUTPUT_PIN = 16'hF005;
  localparam logic [15:0] PCL_IDX_IRQ_STAT = 16'hF010;
  localparam logic [15:0] PCL_IDX_IRQ_MASK = 16'hF011;
  // reset values
  localparam logic [6:0] PCL_FEEDBACK_RST = 7'h60;
  localparam logic [1:0] PCL_PRESCALE_RST = 2'h0;
  localparam logic [2:0] PCL_CLOCK_OUTPUT_PIN_RST = 3'h0;
  // lock settle time and its cycle count at 20 MHz
  localparam int PCL_SETTLE_US = 100;
  localparam int PCL_CLK_KHZ = 20000;
  localparam int PCL_SETTLE_CYCLES = PCL_SETTLE_US * PCL_CLK_KHZ / 1000;
  // interrupt status bit positions
  localparam int PCL_IRQ_LOCKED = 0;
  localparam int PCL_IRQ_LOST = 1;
  // settle timer states
  typedef enum logic [1:0] {
    PCL_ST_OFF = 2'b00,
    PCL_ST_SETTLE = 2'b01,
    PCL_ST_LOCKED = 2'b10
  } pcl_state_type;
endpackage

// ---- rtl/pcl_lock_timer.sv ----
// settle timer that models loop lock acquisition
`timescale 1ns/1ps
`default_nettype none
module pcl_lock_timer #(
  parameter int SETTLE_CYCLES = pcl_pkg::PCL_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic restart,
  input wire logic ref_ok,
  // status
  output logic locked
);
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 1000000) begin : g_bad_settle
    $error("settle count out of range");
  end
  pcl_pkg::pcl_state_type state_reg, state_next;
  logic [19:0] cnt_reg, cnt_next;
  wire logic done = (cnt_reg == 20'(SETTLE_CYCLES - 1));
  // ****************************************
  // state sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      pcl_pkg::PCL_ST_OFF: begin
        cnt_next = 20'h00000;
        if (run && ref_ok) begin
          state_next = pcl_pkg::PCL_ST_SETTLE;
        end
      end
      pcl_pkg::PCL_ST_SETTLE: begin
        cnt_next = cnt_reg + 20'h00001;
        if (done) begin
          state_next = pcl_pkg::PCL_ST_LOCKED;
        end
      end
      pcl_pkg::PCL_ST_LOCKED: begin
        cnt_next = 20'h00000;
      end
      default: begin
        state_next = pcl_pkg::PCL_ST_OFF;
      end
    endcase
    if (!run || restart || !ref_ok) begin
      state_next = pcl_pkg::PCL_ST_OFF;
      cnt_next = 20'h00000;
    end
  end
  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= pcl_pkg::PCL_ST_OFF;
      cnt_reg <= 20'h00000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end
  assign locked = (state_reg == pcl_pkg::PCL_ST_LOCKED);
endmodule
`default_nettype wire

// ---- rtl/pcl_ctrl.sv ----
// loop configuration, commit and lock status with apb registers
`timescale 1ns/1ps
`default_nettype none
module pcl_ctrl #(
  parameter int SETTLE_CYCLES = pcl_pkg::PCL_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reference presence indication from the pin
  input wire logic ref_present,
  // applied settings and lock status
  output logic [6:0] feedback_multiplier,
  output logic [1:0] prescale_code,
  output logic [3:0] prescale_ratio,
  output logic source_select_bit,
  output logic [2:0] clock_output_pin_cfg,
  output logic loop_run,
  output logic core_clk_from_loop,
  output logic lock_flag,
  // interrupt
  output logic irq
);
  // ****************************************
  // overview
  // ****************************************
  // software writes to the four settings land in staged copies only; the applied
  // copies that steer the loop move together, one edge after
  // the loop-on bit rises, so the loop never runs on a mix of
  // old and new settings
  // turning the loop off leaves the applied copies alone; only
  // the next rise of the loop-on bit replaces them
  // lock is reported only after the settle timer has run out
  // with the reference present and the loop on, and it drops
  // as soon as the loop is turned off
  // every output leaves from a flip-flop, so the outputs trail
  // the internal state by one edge
  // the reference indication comes from a pin and passes two
  // flip-flops before the timer looks at it
  // ****************************************
  // parameter check
  // ****************************************
  // the settle counter in the timer is 20 bits wide
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 1000000) begin : g_bad_settle
    $error("settle count out of range");
  end
  // ****************************************
  // apb decode
  // ****************************************
  // word index, the two low address bits are ignored
  wire logic [15:0] idx = paddr[17:2];
  // access phase; writes and read clears act only here
  wire logic access = psel && penable;
  // write and read in the access phase
  wire logic wr = access && pwrite;
  wire logic rd = access && !pwrite;
  // one hit line per mapped register
  wire logic hit_fb = (idx == pcl_pkg::PCL_IDX_FEEDBACK);
  wire logic hit_ps = (idx == pcl_pkg::PCL_IDX_PRESCALE);
  wire logic hit_src = (idx == pcl_pkg::PCL_IDX_SOURCE);
  wire logic hit_pw = (idx == pcl_pkg::PCL_IDX_POWER);
  wire logic hit_lk = (idx == pcl_pkg::PCL_IDX_LOCK);
  wire logic hit_co = (idx == pcl_pkg::PCL_IDX_CLOCK_OUTPUT_PIN);
  wire logic hit_is = (idx == pcl_pkg::PCL_IDX_IRQ_STAT);
  wire logic hit_im = (idx == pcl_pkg::PCL_IDX_IRQ_MASK);
  wire logic hit_any = hit_fb | hit_ps | hit_src | hit_pw | hit_lk | hit_co | hit_is | hit_im;
  // ****************************************
  // write strobes, one per writable register
  // ****************************************
  // the lock and status words take no writes
  wire logic wr_fb = wr && hit_fb;
  wire logic wr_ps = wr && hit_ps;
  wire logic wr_src = wr && hit_src;
  wire logic wr_pw = wr && hit_pw;
  wire logic wr_co = wr && hit_co;
  wire logic wr_im = wr && hit_im;
  // ****************************************
  // staged and applied state
  // ****************************************
  // staged feedback multiplier, as last written
  logic [6:0] fb_stage_reg;
  // staged prescale code
  logic [1:0] ps_stage_reg;
  // staged source select
  logic src_stage_reg;
  // staged clock output setting
  logic [2:0] co_stage_reg;
  // loop-on bit as written by software
  logic on_reg;
  // loop-on bit one edge later, for rise detection
  logic on_prev_reg;
  // sticky event bits and their mask
  logic [1:0] irq_stat_reg, irq_mask_reg;
  // timer lock one edge later, for event detection
  logic lock_prev_reg;
  // two-stage synchroniser for the reference indication
  logic ref_s1_reg, ref_s2_reg;
  // settle timer result
  logic timer_locked;
  // one-cycle pulse on the rise of the loop-on bit
  // commit on loop-on rise
  wire logic commit = on_reg && !on_prev_reg;
  // ****************************************
  // software register writes
  // ****************************************
  // staged feedback multiplier
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fb_stage_reg <= pcl_pkg::PCL_FEEDBACK_RST;
    end else if (wr_fb) begin
      // takes effect at the next commit
      fb_stage_reg <= pwdata[6:0];
    end
  end
  // staged prescale code
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ps_stage_reg <= pcl_pkg::PCL_PRESCALE_RST;
    end else if (wr_ps) begin
      // takes effect at the next commit
      ps_stage_reg <= pwdata[1:0];
    end
  end
  // staged source select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_stage_reg <= 1'b0;
    end else if (wr_src) begin
      // takes effect at the next commit
      src_stage_reg <= pwdata[0];
    end
  end
  // staged clock output setting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      co_stage_reg <= pcl_pkg::PCL_CLOCK_OUTPUT_PIN_RST;
    end else if (wr_co) begin
      // takes effect at the next commit
      co_stage_reg <= pwdata[2:0];
    end
  end
  // loop-on bit, acts at once; its rise commits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on_reg <= 1'b0;
    end else if (wr_pw) begin
      on_reg <= pwdata[0];
    end
  end
  // interrupt mask, acts at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_reg <= 2'h0;
    end else if (wr_im) begin
      irq_mask_reg <= pwdata[1:0];
    end
  end
  // ****************************************
  // commit of staged settings
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      on_prev_reg <= 1'b0;
      feedback_multiplier <= pcl_pkg::PCL_FEEDBACK_RST;
      prescale_code <= pcl_pkg::PCL_PRESCALE_RST;
      source_select_bit <= 1'b0;
      clock_output_pin_cfg <= pcl_pkg::PCL_CLOCK_OUTPUT_PIN_RST;
    end else begin
      // remember the loop-on bit to find its rise
      on_prev_reg <= on_reg;
      // a fall of loop-on leaves the applied settings as they were
      // apply all staged together
      if (commit) begin
        feedback_multiplier <= fb_stage_reg;
        prescale_code <= ps_stage_reg;
        source_select_bit <= src_stage_reg;
        clock_output_pin_cfg <= co_stage_reg;
      end
    end
  end
  // ratio follows the applied code, not the staged one
  // prescale code to ratio
  wire logic [3:0] ratio_next = 4'h1 << prescale_code;
  // ****************************************
  // derived outputs and reference sync
  // ****************************************
  // reference indication, two flip-flops before any use
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
    end else begin
      ref_s1_reg <= ref_present;
      ref_s2_reg <= ref_s1_reg;
    end
  end
  // divide ratio of the applied prescale code
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescale_ratio <= 4'h1;
    end else begin
      prescale_ratio <= ratio_next;
    end
  end
  // loop run and core clock source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_run <= 1'b0;
      core_clk_from_loop <= 1'b0;
    end else begin
      loop_run <= on_reg;
      core_clk_from_loop <= source_select_bit;
    end
  end
  // lock flag, dropped in the commit cycle and whenever off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_flag <= 1'b0;
    end else begin
      lock_flag <= timer_locked && on_reg && !commit;
    end
  end
  // level interrupt from unmasked sticky bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
  // ****************************************
  // lock timer
  // ****************************************
  // the timer restarts on every commit so a new setting relocks
  // settle only with reference and on
  pcl_lock_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(on_reg),
    .restart(commit),
    .ref_ok(ref_s2_reg),
    .locked(timer_locked)
  );
  // ****************************************
  // interrupt status, cleared by read, set wins
  // ****************************************
  // lock gained and lock lost, one-cycle pulses
  wire logic ev_locked = timer_locked && !lock_prev_reg;
  wire logic ev_lost = !timer_locked && lock_prev_reg;
  wire logic stat_rd = rd && hit_is;
  wire logic [1:0] ev_vec = {ev_lost, ev_locked};
  // a read clears only the bits that it reported, taken from the
  // read word latched in setup; an event that lands between the
  // setup and the access edge is kept, and set wins over clear
  wire logic [1:0] stat_clr = stat_rd ? prdata[1:0] : 2'h0;
  wire logic [1:0] stat_next = (irq_stat_reg & ~stat_clr) | ev_vec;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_prev_reg <= 1'b0;
      irq_stat_reg <= 2'h0;
    end else begin
      lock_prev_reg <= timer_locked;
      irq_stat_reg <= stat_next;
    end
  end
  // ****************************************
  // read data, zero wait state
  // ****************************************
  // unmapped words read as zero
  wire logic [31:0] rd_mux =
    hit_fb ? {25'h0000000, fb_stage_reg} :
    hit_ps ? {30'h00000000, ps_stage_reg} :
    hit_src ? {31'h00000000, src_stage_reg} :
    hit_pw ? {31'h00000000, on_reg} :
    hit_lk ? {31'h00000000, lock_flag} :
    hit_co ? {29'h00000000, co_stage_reg} :
    hit_is ? {30'h00000000, irq_stat_reg} :
    hit_im ? {30'h00000000, irq_mask_reg} : 32'h00000000;
  // read data captured in setup so it is valid in access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      // read word of the address seen in setup
      prdata <= rd_mux;
      // unmapped word: error together with the answer
      pslverr <= psel && !penable && !hit_any;
      // answer in the access phase, no wait state
      pready <= psel && !penable;
    end
  end
endmodule
`default_nettype wire

// ---- test/pcl_ctrl_asserts.sv ----
// checker watching the ports of the loop control block
`timescale 1ns/1ps
`default_nettype none
module pcl_ctrl_asserts #(
  parameter int SETTLE_CYCLES = 8
) (
  // clock, reset, apb and reference presence
  input wire logic clk, rst_n, psel, penable, pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic pready, pslverr, ref_present,
  // applied settings and status
  input wire logic [6:0] feedback_multiplier,
  input wire logic [1:0] prescale_code,
  input wire logic [3:0] prescale_ratio,
  input wire logic source_select_bit,
  input wire logic [2:0] clock_output_pin_cfg,
  input wire logic loop_run, core_clk_from_loop, lock_flag, irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // setup phase of an apb transfer
  sequence s_setup;
    psel && !penable;
  endsequence
  // any applied setting moves
  sequence s_applied_moves;
    $changed(prescale_code) || $changed(feedback_multiplier) || $changed(source_select_bit) || $changed(clock_output_pin_cfg);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("answer held too long");
  a_error_with_ready: assert property (pslverr |-> pready) else $error("error without answer");
  a_ratio_from_code: assert property (##1 prescale_ratio == (4'h1 << $past(prescale_code))) else $error("bad ratio");
  a_source_follows: assert property (##1 core_clk_from_loop == $past(source_select_bit)) else $error("bad source");
  a_commit_only: assert property (s_applied_moves |-> $rose(loop_run)) else $error("setting moved outside commit");
  a_lock_when_off: assert property (!loop_run [*2] |-> !lock_flag) else $error("lock while loop off");
  a_lock_after_settle: assert property ($rose(lock_flag) |-> $past(loop_run, SETTLE_CYCLES)) else $error("early lock");
endmodule
bind pcl_ctrl pcl_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .ref_present, .feedback_multiplier, .prescale_code, .prescale_ratio,
  .source_select_bit, .clock_output_pin_cfg, .loop_run, .core_clk_from_loop, .lock_flag, .irq);
`default_nettype wire

// ---- test/pcl_ref_model.sv ----
// behavioural reference source that reports a stable clock when asked
`timescale 1ns/1ps
`default_nettype none
module pcl_ref_model (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic enable,
  // presence seen by the block
  output logic ref_present
);
  // presence follows the bench request one edge later
  always @(posedge clk) begin
    ref_present <= enable;
  end
endmodule
`default_nettype wire

// ---- test/test_pcl_ctrl.sv ----
// testbench for loop configuration, commit and lock
`timescale 1ns/1ps
`default_nettype none
module test_pcl_ctrl;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ref_on = 1'b0, err;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, rdata, prdata;
  logic pready, pslverr, ref_present, source_select_bit, loop_run, core_clk_from_loop, lock_flag, irq;
  logic [6:0] feedback_multiplier;
  logic [1:0] prescale_code;
  logic [3:0] prescale_ratio;
  logic [2:0] clock_output_pin_cfg;
  int mismatches = 0, n_compared = 0, i;
  // 20 MHz clock
  always #25 clk = ~clk;
  pcl_ctrl #(.SETTLE_CYCLES(8)) dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ref_present, .feedback_multiplier, .prescale_code, .prescale_ratio, .source_select_bit, .clock_output_pin_cfg,
    .loop_run, .core_clk_from_loop, .lock_flag, .irq);
  pcl_ref_model ref0 (.clk, .enable(ref_on), .ref_present);
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      mismatches++;
      complete_run();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, '0);
    chk(rdata, exp);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(16'hF000, 32'h60);
    rd(16'hF001, 32'h0);
    rd(16'hF004, 32'h0);
    apb(1'b1, 16'hF004, 32'h1);
    rd(16'hF004, 32'h0);
    rd(16'hF00F, 32'h0);
    chk(32'(err), 32'h1);
    $display("reset and map test done");
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 16'hF001, 32'(i));
      apb(1'b1, 16'hF002, 32'(i & 1));
      apb(1'b1, 16'hF000, 32'(8'h20 + i));
      apb(1'b1, 16'hF005, 32'(i));
      chk(32'(prescale_code), 32'(i == 0 ? 0 : i - 1));
      apb(1'b1, 16'hF003, 32'h0);
      apb(1'b1, 16'hF003, 32'h1);
      repeat (3) @(posedge clk);
      chk(32'(prescale_ratio), 32'(4'h1 << i));
      chk(32'(feedback_multiplier), 32'(8'h20 + i));
      chk(32'(core_clk_from_loop), 32'(i & 1));
      chk(32'(source_select_bit), 32'(i & 1));
      chk(32'(clock_output_pin_cfg), 32'(i));
    end
    repeat (20) @(posedge clk);
    chk(32'(lock_flag), 32'h0);
    $display("commit test done");
    apb(1'b1, 16'hF001, 32'h2);
    apb(1'b1, 16'hF002, 32'h1);
    ref_on <= 1'b1;
    apb(1'b1, 16'hF003, 32'h0);
    apb(1'b1, 16'hF003, 32'h1);
    rdata = '0;
    for (i = 0; i < 60 && rdata[0] !== 1'b1; i++) apb(1'b0, 16'hF004, '0);
    if (i == 60) begin
      mismatches++;
      complete_run();
    end
    chk(32'(lock_flag), 32'h1);
    chk(32'(prescale_ratio), 32'h4);
    chk(32'(core_clk_from_loop), 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, 16'hF011, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    rd(16'hF010, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'b1, 16'hF003, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(lock_flag), 32'h0);
    chk(32'(loop_run), 32'h0);
    repeat (20) @(posedge clk);
    rd(16'hF004, 32'h0);
    rd(16'hF010, 32'h2);
    $display("lock test done");
    complete_run();
  end
endmodule
`default_nettype wire
